//--- verilog/external_memory_port.sv
/*
  External memory bus port: multiplexed low address/data bus, high
  address lines, latch strobe and active-low read and write strobes,
  with per-sector wait states, high-address masking and a bus keeper.
  Assumes a CPU-side request that holds address and data stable until
  done_out pulses, an external transparent-high octal latch on the
  low bus, and a pad that resolves level from value and enable.
*/
// Contract
// - When enabled, addresses above internal SRAM go out as external accesses.
// - One 8-line bus carries low address then data, plus latch, read, write.
// - High address byte on separate lines, with configurable line count.
// - Enabled port overrides general-purpose direction settings on its pins.
// - Port classes each access internal or external and drives pins if external.
// - Valid low address stands on the bus when latch strobe falls.
// - Latch strobe stays low throughout the data transfer phase.
// - Internal accesses may stir bus and latch, never read or write strobes.
// - Disabled port hands pins back to port values and directions.
// - Disabled port never aliases high addresses onto internal SRAM.
// - Four wait-state settings, one of them with no wait.
// - External space splits into sectors, each with its own wait setting.
// - With keeper on, released bus holds the last driven value.
// - Software switches the bus keeper on and off.
// - Port output bits at one switch on bus pull-ups.
// - Codes 00 none, 01 one, 10 two, 11 two plus one before next address.
// - Split zero makes the whole external range one upper sector.
// - Enable one activates alternate pin functions; zero disables the port.
// - Keeper acts whenever its bit is one, whether or not port is enabled.
`include "external_memory_port_params.svh"

module external_memory_port
  import ext_port_pkg::*;
(
  // Clock, reset and freeze
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // Configuration bits
  input wire logic external_port_on_in,
  input wire logic bus_keeper_on_in,
  input wire logic [2:0] sector_split_sel_in,
  input wire logic [1:0] wait_state_sel_hi_in,
  input wire logic [1:0] wait_state_sel_lo_in,
  input wire logic [2:0] high_mask_sel_in,
  // CPU data-space request
  input wire logic req_in,
  input wire logic req_write_in,
  input wire logic [15:0] req_addr_in,
  input wire logic [7:0] req_wdata_in,
  output logic done_out,
  output logic ext_hit_out,
  output logic [7:0] rdata_out,
  // General-purpose port settings for the shared pins
  input wire logic [7:0] low_port_value_in,
  input wire logic [7:0] low_port_dir_in,
  input wire logic [7:0] high_port_value_in,
  input wire logic [7:0] high_port_dir_in,
  input wire logic rd_port_value_in,
  input wire logic wr_port_value_in,
  input wire logic ale_port_value_in,
  input wire logic [2:0] ctl_port_dir_in,
  // Multiplexed low bus pads; enable low means driving
  input wire logic [7:0] muxed_low_bus_in,
  output logic [7:0] muxed_low_bus_out,
  output logic [7:0] muxed_low_bus_oe_n_out,
  output logic [7:0] muxed_low_bus_pullup_out,
  output logic [7:0] muxed_low_bus_keep_out,
  // High address and strobe pads
  output logic [7:0] high_address_lines_out,
  output logic [7:0] high_address_lines_oe_n_out,
  output logic ale_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic [2:0] ctl_oe_n_out
);

  // ****************************************************************
  // Access decode
  // ****************************************************************
  logic [1:0] wait_code;
  logic is_ext;
  logic [7:0] high_used;

  sector_wait_sel u_sector (
    .addr_in(req_addr_in),
    .sector_split_sel_in(sector_split_sel_in),
    .wait_state_sel_hi_in(wait_state_sel_hi_in),
    .wait_state_sel_lo_in(wait_state_sel_lo_in),
    .wait_code_out(wait_code)
  );

  // External only when enabled; disabled high addresses reach nothing
  assign is_ext = external_port_on_in &&
                  (req_addr_in >= `EXT_BASE_ADDR);

  // Mask 0 keeps all eight high lines; n releases the top n (max 7)
  always_comb begin
    high_used = 8'hFF >> high_mask_sel_in;
    if (high_mask_sel_in == 3'h0) begin
      high_used = 8'hFF;
    end
  end

  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  seq_state_t state_q;
  logic [3:0] cnt_q;
  logic [1:0] code_q;
  logic ext_q;
  logic write_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic [3:0] strobe_len;

  // Strobe length: base plus 0, 1, 2 or 2 wait cycles
  always_comb begin
    unique case (code_q)
      `WAIT_NONE: strobe_len = `STROBE_BASE_CYCLES;
      `WAIT_ONE: strobe_len = `STROBE_BASE_CYCLES + 4'h1;
      `WAIT_TWO: strobe_len = `STROBE_BASE_CYCLES + 4'h2;
      `WAIT_TWO_HOLD: strobe_len = `STROBE_BASE_CYCLES + 4'h2;
    endcase
  end

  // Every access walks latch then strobe so internal ones stir the bus too
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      code_q <= `WAIT_NONE;
      ext_q <= 1'b0;
      write_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= `BUS_RESET_VALUE;
    end else if (clk_en_in) begin
      unique case (state_q)
        ST_IDLE: begin
          if (req_in) begin
            state_q <= ST_LATCH;
            ext_q <= is_ext;
            write_q <= req_write_in;
            addr_q <= req_addr_in;
            wdata_q <= req_wdata_in;
            code_q <= is_ext ? wait_code : `WAIT_NONE;
          end
        end
        ST_LATCH: begin
          state_q <= ST_STROBE;
          cnt_q <= 4'h1;
        end
        ST_STROBE: begin
          if (cnt_q >= strobe_len) begin
            state_q <= ST_DONE;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        ST_DONE: begin
          // Extra cycle before the next address on the slowest code
          state_q <= (code_q == `WAIT_TWO_HOLD) ? ST_HOLD : ST_IDLE;
          cnt_q <= 4'h0;
        end
        ST_HOLD: begin
          if (cnt_q >= `HOLD_EXTRA_CYCLES - 4'h1) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // CPU answer
  // ****************************************************************
  // Read data caught at the edge that raises the read strobe: the pin is
  // registered, so the strobe is still low while the pad is sampled
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      done_out <= 1'b0;
      ext_hit_out <= 1'b0;
      rdata_out <= 8'h00;
    end else if (clk_en_in) begin
      done_out <= (state_q == ST_DONE);
      if (state_q == ST_DONE) begin
        ext_hit_out <= ext_q;
        if (ext_q && !write_q) begin
          rdata_out <= muxed_low_bus_in;
        end
      end
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  logic in_strobe;
  logic bus_drive;

  assign in_strobe = (state_q == ST_STROBE);
  // Bus is driven in latch phase, and in strobe phase only for writes
  assign bus_drive = (state_q == ST_LATCH) ||
                     (in_strobe && write_q);

  // Registered pins; port settings return whenever the enable is low
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      muxed_low_bus_out <= `BUS_RESET_VALUE;
      muxed_low_bus_oe_n_out <= 8'hFF;
      high_address_lines_out <= 8'h00;
      high_address_lines_oe_n_out <= 8'hFF;
      ale_out <= 1'b0;
      rd_n_out <= 1'b1;
      wr_n_out <= 1'b1;
      ctl_oe_n_out <= 3'h7;
    end else if (clk_en_in) begin
      if (external_port_on_in) begin
        // Latch phase: address with strobe high; falls as strobe begins
        muxed_low_bus_out <= (state_q == ST_LATCH) ? addr_q[7:0] :
                             wdata_q;
        muxed_low_bus_oe_n_out <= bus_drive ? 8'h00 : 8'hFF;
        high_address_lines_out <= (addr_q[15:8] & high_used) |
                                  (high_port_value_in & ~high_used);
        high_address_lines_oe_n_out <= ~(high_used |
                                         high_port_dir_in);
        ale_out <= (state_q == ST_LATCH);
        rd_n_out <= ~(in_strobe && ext_q && !write_q);
        wr_n_out <= ~(in_strobe && ext_q && write_q);
        ctl_oe_n_out <= 3'h0;
      end else begin
        muxed_low_bus_out <= low_port_value_in;
        muxed_low_bus_oe_n_out <= ~low_port_dir_in;
        high_address_lines_out <= high_port_value_in;
        high_address_lines_oe_n_out <= ~high_port_dir_in;
        ale_out <= ale_port_value_in;
        rd_n_out <= rd_port_value_in;
        wr_n_out <= wr_port_value_in;
        ctl_oe_n_out <= ~ctl_port_dir_in;
      end
    end
  end

  // Keeper and pull-ups; keeper does not look at the port enable
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      muxed_low_bus_keep_out <= 8'h00;
      muxed_low_bus_pullup_out <= 8'h00;
    end else if (clk_en_in) begin
      // One register in the pad loop: a second stage would make a
      // released line swing between two old levels instead of holding
      muxed_low_bus_keep_out <= bus_keeper_on_in ?
                                muxed_low_bus_in : 8'h00;
      // Pull-up on lines set to one in software; while disabled, only on released ones
      muxed_low_bus_pullup_out <= low_port_value_in &
                                  ~(external_port_on_in ? 8'h00 :
                                    low_port_dir_in);
    end
  end

endmodule : external_memory_port

//--- verilog/external_memory_port_params.svh
/*
  Constants for the external memory bus port: address bounds,
  wait-state codes, cycle counts and the bus reset value.
  Assumes inclusion by bare name from the sector decode and the top module.
*/
`ifndef EXT_PORT_PARAMS_SVH
`define EXT_PORT_PARAMS_SVH

// ****************************************************************
// Address map
// ****************************************************************
`define EXT_BASE_ADDR 16'h2100
`define EXT_TOP_ADDR 16'hFFFF

// ****************************************************************
// Wait-state codes and counts
// ****************************************************************
`define WAIT_NONE 2'h0
`define WAIT_ONE 2'h1
`define WAIT_TWO 2'h2
`define WAIT_TWO_HOLD 2'h3
`define STROBE_BASE_CYCLES 4'h1
`define HOLD_EXTRA_CYCLES 4'h1

// ****************************************************************
// Reset values of the pin-side registers
// ****************************************************************
`define BUS_RESET_VALUE 8'h00

`endif

//--- verilog/external_memory_port_pkg.sv
/*
  Types shared by the external memory bus port.
  Assumes nothing beyond the constants header.
*/
package ext_port_pkg;

  // Access sequencer states, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_LATCH  = 3'b001,
    ST_STROBE = 3'b011,
    ST_DONE   = 3'b010,
    ST_HOLD   = 3'b110
  } seq_state_t;

endpackage : ext_port_pkg

//--- verilog/sector_wait_sel.sv
/*
  Sector decode: picks the 2-bit wait-state code for an external address
  from the sector split field and both sector codes.
  Assumes the address has already been classed as external.
*/
`include "external_memory_port_params.svh"

module sector_wait_sel (
  input wire logic [15:0] addr_in,
  input wire logic [2:0] sector_split_sel_in,
  input wire logic [1:0] wait_state_sel_hi_in,
  input wire logic [1:0] wait_state_sel_lo_in,
  output logic [1:0] wait_code_out
);

  logic [15:0] upper_start;

  // Upper sector start for split codes 2..7; 0 and 1 mean one sector
  always_comb begin
    upper_start = {sector_split_sel_in, 13'h0000};
    if (sector_split_sel_in[2:1] == 2'h0) begin
      wait_code_out = wait_state_sel_hi_in;
    end else if (addr_in >= upper_start) begin
      wait_code_out = wait_state_sel_hi_in;
    end else begin
      wait_code_out = wait_state_sel_lo_in;
    end
  end

endmodule : sector_wait_sel

//--- test/external_memory_port_port_sva.sv
/*
  Checker for the external memory port pins and strobes.
  Assumes configuration and request inputs stay steady during an access.
*/
module port_pin_checker (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Configuration and request
  input wire logic external_port_on_in,
  input wire logic bus_keeper_on_in,
  input wire logic [2:0] sector_split_sel_in,
  input wire logic [1:0] wait_state_sel_hi_in,
  input wire logic req_in,
  input wire logic [15:0] req_addr_in,
  input wire logic [7:0] req_wdata_in,
  input wire logic [7:0] low_port_value_in,
  input wire logic [7:0] low_port_dir_in,
  // Pins
  input wire logic [7:0] muxed_low_bus_in,
  input wire logic [7:0] muxed_low_bus_out,
  input wire logic [7:0] muxed_low_bus_oe_n_out,
  input wire logic [7:0] muxed_low_bus_pullup_out,
  input wire logic [7:0] muxed_low_bus_keep_out,
  input wire logic ale_out,
  input wire logic rd_n_out,
  input wire logic wr_n_out
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  logic [3:0] low_cnt_q;
  logic [3:0] exp_len;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Strobe width so far; cleared once both strobes are high
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || (rd_n_out && wr_n_out)) low_cnt_q <= 4'h0;
    else low_cnt_q <= low_cnt_q + 4'h1;
  end
  // Single-sector strobe length from the upper code
  always_comb begin
    exp_len = (wait_state_sel_hi_in == 2'h0) ? 4'h1 :
              (wait_state_sel_hi_in == 2'h1) ? 4'h2 : 4'h3;
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_excl; !(!rd_n_out && !wr_n_out); endproperty
  a_excl: assert property (p_excl) else $error("both strobes low");
  property p_ale; (!rd_n_out || !wr_n_out) |-> !ale_out; endproperty
  a_ale: assert property (p_ale) else $error("latch open in strobe");
  property p_fall; $fell(ale_out) && external_port_on_in |->
    $past(muxed_low_bus_out) == req_addr_in[7:0] &&
    $past(muxed_low_bus_oe_n_out) == 8'h00; endproperty
  a_fall: assert property (p_fall) else $error("bad latched address");
  property p_len; $rose(rd_n_out && wr_n_out) &&
    sector_split_sel_in < 3'h2 |-> low_cnt_q == exp_len; endproperty
  a_len: assert property (p_len) else $error("strobe length wrong");
  property p_int; req_in && req_addr_in < 16'h2100 |->
    rd_n_out && wr_n_out; endproperty
  a_int: assert property (p_int) else $error("strobe on internal");
  property p_rd; !rd_n_out |-> muxed_low_bus_oe_n_out == 8'hFF; endproperty
  a_rd: assert property (p_rd) else $error("bus driven in read");
  property p_wr; !wr_n_out |-> muxed_low_bus_oe_n_out == 8'h00 &&
    muxed_low_bus_out == req_wdata_in; endproperty
  a_wr: assert property (p_wr) else $error("write data wrong");
  property p_back; !external_port_on_in && $past(!external_port_on_in) &&
    !$past(sys_rst_in) |-> muxed_low_bus_out == $past(low_port_value_in)
    && muxed_low_bus_oe_n_out == ~$past(low_port_dir_in); endproperty
  a_back: assert property (p_back) else $error("port pins wrong");
  property p_keep; bus_keeper_on_in && $past(bus_keeper_on_in) &&
    !$past(sys_rst_in) |-> muxed_low_bus_keep_out ==
    $past(muxed_low_bus_in); endproperty
  a_keep: assert property (p_keep) else $error("keeper lost value");
  property p_pull; external_port_on_in && $past(external_port_on_in) &&
    !$past(sys_rst_in) |-> muxed_low_bus_pullup_out ==
    $past(low_port_value_in); endproperty
  a_pull: assert property (p_pull) else $error("pull-up wrong");
endmodule : port_pin_checker

bind external_memory_port port_pin_checker port_pin_checker_inst (.*);

//--- test/external_memory_port_sram_model.sv
/*
  External SRAM behind a transparent-high octal latch, with pad level.
  Assumes the port pins are wired straight to it.
*/
module ext_sram_model (
  // Clock and port pins
  input wire logic clk_in,
  input wire logic ale_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic [7:0] addr_hi_in,
  input wire logic [7:0] bus_out_in,
  input wire logic [7:0] bus_oe_n_in,
  input wire logic [7:0] pullup_in,
  input wire logic [7:0] keep_in,
  input wire logic keep_on_in,
  // Resolved pad level
  output logic [7:0] pad_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] lat_q = 8'h00;
  // ****************************************************************
  // Latch and array
  // ****************************************************************
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8] ^ 8'h5A;
  end
  // Pins move only on clock edges, so a gate looked at on every edge
  // behaves as the transparent latch; no race with the pins changing
  always @(posedge clk_in) begin
    if (ale_in) lat_q <= pad_out;
    // Write data taken on every strobe edge; the last one stays
    if (!wr_n_in) mem[{addr_hi_in, lat_q}] <= pad_out;
  end
  // Pad: port, then memory on read, keeper, pull-up, else a changing value
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!bus_oe_n_in[i]) pad_out[i] = bus_out_in[i];
      else if (!rd_n_in) pad_out[i] = mem[{addr_hi_in, lat_q}][i];
      else if (keep_on_in) pad_out[i] = keep_in[i];
      else if (pullup_in[i]) pad_out[i] = 1'b1;
      else pad_out[i] = ~bus_out_in[i];
    end
  end
endmodule : ext_sram_model

//--- test/tb_top.sv
/*
  Self-checking bench for the external memory port with an SRAM model.
  Assumes the checker is bound by its own file.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 0, sys_rst_in = 1, clk_en_in = 1;
  logic external_port_on_in = 0, bus_keeper_on_in = 0, req_in = 0;
  logic [2:0] sector_split_sel_in = 0, high_mask_sel_in = 0;
  logic [2:0] ctl_port_dir_in = 3'h5;
  logic [1:0] wait_state_sel_hi_in = 0, wait_state_sel_lo_in = 0;
  logic req_write_in = 0, rd_port_value_in = 1, wr_port_value_in = 1;
  logic ale_port_value_in = 0, done_out, ext_hit_out, ale_out;
  logic [15:0] req_addr_in = 0, a;
  logic [7:0] req_wdata_in = 0, low_port_value_in = 0, low_port_dir_in = 0;
  logic [7:0] high_port_value_in = 8'hC3, high_port_dir_in = 0, rdata_out;
  logic [7:0] muxed_low_bus_in, muxed_low_bus_out, muxed_low_bus_oe_n_out;
  logic [7:0] muxed_low_bus_pullup_out, muxed_low_bus_keep_out, d;
  logic [7:0] high_address_lines_out, high_address_lines_oe_n_out;
  logic rd_n_out, wr_n_out;
  logic [2:0] ctl_oe_n_out;
  logic [7:0] sh [0:65535];
  int n_fail = 0, tests_run = 0, seed = 1055;
  external_memory_port external_memory_port_inst (.*);
  ext_sram_model ext_sram_model_inst (.clk_in(ref_clk_in), .ale_in(ale_out),
    .rd_n_in(rd_n_out), .wr_n_in(wr_n_out),
    .addr_hi_in(high_address_lines_out), .bus_out_in(muxed_low_bus_out),
    .bus_oe_n_in(muxed_low_bus_oe_n_out),
    .pullup_in(muxed_low_bus_pullup_out), .keep_in(muxed_low_bus_keep_out),
    .keep_on_in(bus_keeper_on_in), .pad_out(muxed_low_bus_in));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  always #5 ref_clk_in = ~ref_clk_in;
  task automatic chk(input string what, input logic [15:0] exp, got);
    tests_run++;
    if (exp !== got) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic stop_test();
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  // Expected strobe length: pick the sector, then decode its code
  function automatic logic [15:0] wait_len(input logic [15:0] ad);
    logic [1:0] code;
    code = wait_state_sel_lo_in;
    if (sector_split_sel_in < 3'h2 || ad >= {sector_split_sel_in, 13'h0})
      code = wait_state_sel_hi_in;
    if (!external_port_on_in || ad < 16'h2100) code = 2'h0;
    return (code == 2'h0) ? 16'h1 : (code == 2'h1) ? 16'h2 : 16'h3;
  endfunction : wait_len
  // One byte access; two spare cycles follow every access, enough for the hold code
  task automatic acc(input logic w, input logic [15:0] ad,
                     input logic [7:0] dt);
    int n;
    logic ext;
    logic [15:0] len;
    ext = external_port_on_in && ad >= 16'h2100;
    len = wait_len(ad);
    req_write_in = w;
    req_addr_in = ad;
    req_wdata_in = dt;
    req_in = 1;
    n = 0;
    do begin @(negedge ref_clk_in); n++; end while (done_out !== 1 && n < 20);
    chk("done", 16'h1, done_out);
    chk("cycles", len + 16'h3, 16'(n));
    req_in = 0;
    repeat (2) @(negedge ref_clk_in);
    chk("ext_hit", ext, ext_hit_out);
    if (ext && w) sh[ad] = dt;
    if (ext && !w) chk("rdata", sh[ad], rdata_out);
  endtask : acc
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    for (int i = 0; i < 65536; i++) sh[i] = i[7:0] ^ i[15:8] ^ 8'h5A;
    repeat (6) @(negedge ref_clk_in);
    sys_rst_in = 0;
    external_port_on_in = 1;
    @(negedge ref_clk_in);
    // Range edges with every wait code
    for (int c = 0; c < 4; c++) begin
      wait_state_sel_hi_in = 2'(c);
      acc(1, 16'h2100, 8'hA5 ^ 8'(c));
      acc(0, 16'h2100, 0);
      acc(0, 16'hFFFF, 0);
      acc(0, 16'h20FF, 0);
    end
    // Random sectors, codes and addresses, each read back
    repeat (60) begin
      sector_split_sel_in = 3'($random(seed));
      wait_state_sel_hi_in = 2'($random(seed));
      wait_state_sel_lo_in = 2'($random(seed));
      a = 16'($random(seed));
      d = 8'($random(seed));
      acc(1'($random(seed)), a, d);
      acc(0, a, 0);
    end
    // Pull-ups follow the port bits, then cleared for sleep
    low_port_value_in = 8'($random(seed));
    repeat (2) @(negedge ref_clk_in);
    chk("pullup", low_port_value_in, muxed_low_bus_pullup_out);
    low_port_value_in = 0;
    // High lines: masked ones return to the port
    high_port_dir_in = 8'($random(seed));
    high_mask_sel_in = 3'h3;
    repeat (2) @(negedge ref_clk_in);
    chk("hi_oe", {~high_port_dir_in[7:5], 5'h00},
        high_address_lines_oe_n_out);
    chk("hi_val", high_port_value_in[7:5], high_address_lines_out[7:5]);
    high_mask_sel_in = 3'h0;
    repeat (2) @(negedge ref_clk_in);
    chk("hi_oe", 8'h00, high_address_lines_oe_n_out);
    chk("ctl_oe", 3'h0, ctl_oe_n_out);
    // Disabled: no aliasing and plain port pins, keeper still live
    bus_keeper_on_in = 1;
    external_port_on_in = 0;
    low_port_value_in = 8'($random(seed));
    low_port_dir_in = 8'($random(seed));
    acc(0, 16'h8000, 0);
    chk("bus", low_port_value_in, muxed_low_bus_out);
    chk("hi", high_port_value_in, high_address_lines_out);
    chk("ctl_oe", {~ctl_port_dir_in}, ctl_oe_n_out);
    low_port_dir_in = 0;
    repeat (3) @(negedge ref_clk_in);
    bus_keeper_on_in = 0;
    repeat (2) @(negedge ref_clk_in);
    chk("keep", 8'h00, muxed_low_bus_keep_out);
    stop_test();
  end
  // Watchdog well beyond the expected run
  initial begin
    #50us;
    n_fail++;
    stop_test();
  end
endmodule : tb_top
